// File: core/rsv_pkg.sv
// Constants for the reset sequencer and vector select block
package rsv_pkg;
  // Timing in oscillator cycles
  localparam int unsigned RSV_OSC_DELAY_CYC = 4096;
  localparam int unsigned RSV_DRIVE_CYC = 16;
  localparam int unsigned RSV_SAMPLE_CYC = 9;
  localparam int unsigned RSV_CNT_W = 13;
  // Reset vectors
  localparam logic [15:0] RSV_VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] RSV_VEC_WATCHDOG = 16'hFFFA;
  localparam logic [15:0] RSV_VEC_NORMAL = 16'hFFFE;
  // Operating mode codes {special_mode_pin, b, a}
  localparam logic [2:0] RSV_MODE_SPEC_SINGLE = 3'h0;
  localparam logic [2:0] RSV_MODE_SPEC_PERIPH = 3'h2;
  localparam logic [2:0] RSV_MODE_USER_SINGLE = 3'h4;
  // Register bus offsets
  localparam logic [3:0] RSV_REG_STATUS = 4'h0;
  localparam logic [3:0] RSV_REG_INTERRUPT_CONTROL = 4'h1;
  localparam logic [3:0] RSV_REG_PULLUP_CONTROL = 4'h2;
  localparam logic [3:0] RSV_REG_PORT_E_ASSIGNMENT = 4'h3;
  localparam logic [3:0] RSV_REG_VECTOR = 4'h4;
  // Field positions
  localparam int unsigned RSV_IC_EDGE_BIT = 0;
  localparam int unsigned RSV_IC_ENABLE_BIT = 1;
  localparam int unsigned RSV_IC_IMASK_BIT = 2;
  localparam int unsigned RSV_IC_XMASK_BIT = 3;
  localparam int unsigned RSV_PE_BUSCLK_BIT = 0;
  localparam int unsigned RSV_PE_RW_BIT = 1;
  localparam int unsigned RSV_PE_QUEUE_BIT = 2;
  // Reset values
  localparam logic [7:0] RSV_IC_RESET = 8'h0E;
  localparam logic [7:0] RSV_PU_RESET = 8'h01;
endpackage

// File: core/rsv_reset_sequencer.sv
// Reset sequencer with vector select, strap capture and reset pin defaults
//
// Contract
// - Reset starts on power-on, enabled watchdog timeout, enabled clock monitor fail, or pin low.
// - Any reset pulls the bidirectional reset pin low through an open-drain driver.
// - Power-on reset entry is asynchronous; other entries and every release are synchronous to the device clock.
// - Power-on or clock monitor failure holds pin low 4096 cycles first.
// - Recovery drives pin low 16 to 17 cycles then releases it.
// - Nine cycles after release sample pin; low clears latched failure flags.
// - Pin high with clock monitor fail latched selects vector FFFC, over watchdog.
// - Pin high, no clock monitor fail, watchdog latched selects vector FFFA.
// - Otherwise or after external reset, the normal vector FFFE is used.
// - Operating mode comes from special-mode and two mode select pins during reset.
// - Mode select pins pulled down in reset; special-mode pin pulled up as input.
// - In expanded modes mode select pins may output queue tracking after reset.
// - Reset leaves request pin enabled, level-sensitive and masked.
// - Reset sets the nonmaskable interrupt mask bit.
// - Both request pins pulled up in and after reset until pull-up bit cleared.
// - Bus clock output is half crystal rate; off in user single-chip unless enabled.
// - Special single-chip runs bus clock at reset; special peripheral makes it input.
// - Read/write pin is pulled-up input until read/write enable bit is set.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module rsv_reset_sequencer
  import rsv_pkg::*;
#(
  parameter int unsigned OSC_DELAY_CYC = RSV_OSC_DELAY_CYC
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic watchdog_timer_timeout_in,
  input wire logic watchdog_timer_enable_in,
  input wire logic clock_monitor_fail_in,
  input wire logic clock_monitor_enable_in,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n_out,
  output logic cpu_reset_out,
  output logic [15:0] vector_addr_out,
  output logic vector_valid_out,
  input wire logic special_mode_pin_in,
  input wire logic mode_select_pin_a_in,
  input wire logic mode_select_pin_b_in,
  output logic mode_pulldown_out,
  output logic special_mode_pullup_out,
  output logic [2:0] op_mode_out,
  output logic queue_track_en_out,
  output logic request_pin_enable_bit_out,
  output logic request_edge_mode_out,
  output logic request_mask_out,
  output logic nonmaskable_mask_out,
  output logic request_pullup_out,
  output logic bus_clock_output_out,
  output logic bus_clock_oe_n_out,
  output logic rw_pullup_out,
  output logic read_write_enable_bit_out,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);

  initial begin
    if (OSC_DELAY_CYC < 1 || OSC_DELAY_CYC >= (1 << RSV_CNT_W)) begin
      $error("OSC_DELAY_CYC out of range");
    end
    if (RSV_DRIVE_CYC < 1 || RSV_DRIVE_CYC >= (1 << RSV_CNT_W)) begin
      $error("drive count out of range");
    end
    if (RSV_SAMPLE_CYC < 1 || RSV_SAMPLE_CYC >= (1 << RSV_CNT_W)) begin
      $error("settle count out of range");
    end
  end

  typedef enum logic [2:0] {
    RSV_ST_OSC_WAIT,
    RSV_ST_DRIVE,
    RSV_ST_SETTLE,
    RSV_ST_RUN
  } rsv_state_t;

  // Counter wide enough for the oscillator wait, the longest phase

  localparam logic [RSV_CNT_W-1:0] OSC_LAST = RSV_CNT_W'(OSC_DELAY_CYC - 1);
  localparam logic [RSV_CNT_W-1:0] DRIVE_LAST = RSV_CNT_W'(RSV_DRIVE_CYC - 1);
  localparam logic [RSV_CNT_W-1:0] SAMPLE_LAST = RSV_CNT_W'(RSV_SAMPLE_CYC - 1);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [1:0] pin_sync;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic pin_low;
  logic internal_cause;

  // Two flops on reset pin and strap pins
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_sync <= 2'h0;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[0], reset_pin_in};
      strap_s1 <= {special_mode_pin_in, mode_select_pin_b_in, mode_select_pin_a_in};
      strap_s2 <= strap_s1;
    end
  end
  // Pin seen low once it has crossed both flops
  assign pin_low = ~pin_sync[1];

  // ==========================================================
  // Reset causes
  // ==========================================================
  logic wdog_cause;
  logic cmon_cause;

  // A cause only counts while its own enable is set
  assign wdog_cause = watchdog_timer_timeout_in & watchdog_timer_enable_in;
  assign cmon_cause = clock_monitor_fail_in & clock_monitor_enable_in;
  // Either internal cause restarts the sequence from the run state
  assign internal_cause = wdog_cause | cmon_cause;

  // ==========================================================
  // Sequencer
  // ==========================================================
  rsv_state_t state;
  logic [RSV_CNT_W-1:0] cnt;
  logic wdog_flag;
  logic cmon_flag;
  logic settle_end;

  // Last cycle of a counted phase
  function automatic logic phase_done(input logic [RSV_CNT_W-1:0] count,
      input logic [RSV_CNT_W-1:0] last);
    phase_done = (count == last);
  endfunction

  // Phase order after a cause:
  //   oscillator wait, pin held low, only after power-on or clock monitor fail
  //   drive, pin held low for the fixed recovery count
  //   settle, pin released and sampled on the last cycle
  //   run, core released with the chosen vector
  // A pin that rises too slowly reads as an external request and restarts drive.
  assign settle_end = (state == RSV_ST_SETTLE) && phase_done(cnt, SAMPLE_LAST);

  // Power-on is the async reset; later causes restart in clock domain
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= RSV_ST_OSC_WAIT;
      cnt <= '0;
    end else begin
      unique case (state)
        RSV_ST_OSC_WAIT: begin
          if (phase_done(cnt, OSC_LAST)) begin
            state <= RSV_ST_DRIVE;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        RSV_ST_DRIVE: begin
          if (phase_done(cnt, DRIVE_LAST)) begin
            state <= RSV_ST_SETTLE;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        RSV_ST_SETTLE: begin
          if (phase_done(cnt, SAMPLE_LAST)) begin
            state <= RSV_ST_RUN;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        RSV_ST_RUN: begin
          cnt <= '0;
          if (cmon_cause) begin
            state <= RSV_ST_OSC_WAIT;
          end else if (internal_cause | pin_low) begin
            state <= RSV_ST_DRIVE;
          end
        end
      endcase
    end
  end

  // Failure flags latch on cause in run; cleared by a low sample, or in run once the vector is valid and no cause is present
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wdog_flag <= 1'b0;
      cmon_flag <= 1'b0;
    end else if (state == RSV_ST_RUN) begin
      if (wdog_cause) begin
        wdog_flag <= 1'b1;
      end
      if (cmon_cause) begin
        cmon_flag <= 1'b1;
      end
      if (vector_valid_out && !internal_cause) begin
        wdog_flag <= 1'b0;
        cmon_flag <= 1'b0;
      end
    end else if (settle_end && pin_low) begin
      wdog_flag <= 1'b0;
      cmon_flag <= 1'b0;
    end
  end

  // Vector chosen at end of settle window
  // Vector and valid stand until the next sequence starts
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vector_addr_out <= RSV_VEC_NORMAL;
      vector_valid_out <= 1'b0;
    end else if (settle_end) begin
      vector_valid_out <= 1'b1;
      if (pin_low) begin
        vector_addr_out <= RSV_VEC_NORMAL;
      end else if (cmon_flag) begin
        vector_addr_out <= RSV_VEC_CLKMON;
      end else if (wdog_flag) begin
        vector_addr_out <= RSV_VEC_WATCHDOG;
      end else begin
        vector_addr_out <= RSV_VEC_NORMAL;
      end
    end else if (state != RSV_ST_RUN) begin
      vector_valid_out <= 1'b0;
    end
  end

  // Open drain: drive low in wait and drive phases
  // The pin is never driven high; the external pull-up raises it
  // Async reset forces the drive even before the first clock edge
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n_out = !resetn_in ? 1'b0 :
      !(state == RSV_ST_OSC_WAIT || state == RSV_ST_DRIVE);
  assign cpu_reset_out = !resetn_in || (state != RSV_ST_RUN);

  // ==========================================================
  // Mode straps
  // ==========================================================
  logic [2:0] mode;
  logic in_reset;
  logic expanded;

  assign in_reset = cpu_reset_out;
  // Mode captured continuously while reset active
  // Straps pass the same two flops as the reset pin
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode <= RSV_MODE_USER_SINGLE;
    end else if (state != RSV_ST_RUN) begin
      mode <= strap_s2;
    end
  end
  assign op_mode_out = mode;
  assign expanded = mode[0];
  assign mode_pulldown_out = in_reset;
  assign special_mode_pullup_out = 1'b1;

  // ==========================================================
  // Control registers
  // ==========================================================
  logic [7:0] int_ctrl;
  logic [7:0] pullup_ctrl;
  logic [7:0] port_e_assign;
  logic [7:0] port_e_default;

  // Bus clock runs at reset in every mode except user single-chip
  always_comb begin
    port_e_default = 8'h00;
    port_e_default[RSV_PE_BUSCLK_BIT] = (mode != RSV_MODE_USER_SINGLE);
  end

  // Register writes; reset state reloads defaults
  // Writes are refused while the core is held, so software always
  // starts from the reset defaults; no write can race the reload
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      int_ctrl <= RSV_IC_RESET;
      pullup_ctrl <= RSV_PU_RESET;
      port_e_assign <= 8'h00;
    end else if (in_reset) begin
      int_ctrl <= RSV_IC_RESET;
      pullup_ctrl <= RSV_PU_RESET;
      port_e_assign <= port_e_default;
    end else if (wr_in) begin
      unique case (addr_in)
        RSV_REG_INTERRUPT_CONTROL: int_ctrl <= wdata_in;
        RSV_REG_PULLUP_CONTROL: pullup_ctrl <= wdata_in;
        RSV_REG_PORT_E_ASSIGNMENT: port_e_assign <= wdata_in;
        default: ;
      endcase
    end
  end

  // Read data one cycle after strobe
  // Unmapped offsets and idle cycles read as zero
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        RSV_REG_STATUS: rdata_out <= {2'h0, cmon_flag, wdog_flag, vector_valid_out, mode};
        RSV_REG_INTERRUPT_CONTROL: rdata_out <= int_ctrl;
        RSV_REG_PULLUP_CONTROL: rdata_out <= pullup_ctrl;
        RSV_REG_PORT_E_ASSIGNMENT: rdata_out <= port_e_assign;
        RSV_REG_VECTOR: rdata_out <= vector_addr_out[7:0];
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  assign request_pin_enable_bit_out = int_ctrl[RSV_IC_ENABLE_BIT];
  assign request_edge_mode_out = int_ctrl[RSV_IC_EDGE_BIT];
  assign request_mask_out = int_ctrl[RSV_IC_IMASK_BIT];
  assign nonmaskable_mask_out = int_ctrl[RSV_IC_XMASK_BIT];
  assign request_pullup_out = pullup_ctrl[0];
  assign queue_track_en_out = expanded && !in_reset && port_e_assign[RSV_PE_QUEUE_BIT];
  assign read_write_enable_bit_out = port_e_assign[RSV_PE_RW_BIT];
  assign rw_pullup_out = !port_e_assign[RSV_PE_RW_BIT];

  // ==========================================================
  // Bus clock output: half the core clock
  // ==========================================================
  logic bus_clk_div;
  // Free running divider; the enable bit only gates the pin
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_clk_div <= 1'b0;
    end else begin
      bus_clk_div <= ~bus_clk_div;
    end
  end
  assign bus_clock_output_out = bus_clk_div & port_e_assign[RSV_PE_BUSCLK_BIT];
  assign bus_clock_oe_n_out = (mode == RSV_MODE_SPEC_PERIPH);

endmodule

// File: testbench/rsv_sva.sv
// Port checker for the reset sequencer
`timescale 1ns/1ps
module rsv_sva
  import rsv_pkg::*;
#(
  parameter int unsigned OSC_DELAY_CYC = 8
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n_out,
  input wire logic cpu_reset_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic vector_valid_out,
  input wire logic mode_pulldown_out,
  input wire logic special_mode_pullup_out,
  input wire logic [2:0] op_mode_out,
  input wire logic request_pin_enable_bit_out,
  input wire logic request_edge_mode_out,
  input wire logic request_mask_out,
  input wire logic nonmaskable_mask_out,
  input wire logic request_pullup_out,
  input wire logic bus_clock_oe_n_out
);
  logic [15:0] lowcnt;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // ======
  // Length of the current pin drive phase
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lowcnt <= 16'h0000;
    end else begin
      lowcnt <= reset_pin_oe_n_out ? 16'h0000 : lowcnt + 16'h0001;
    end
  end
  // Assertions and covers
  a_entry_async: assert property (
    $rose(resetn_in) |-> !reset_pin_oe_n_out && cpu_reset_out && !vector_valid_out)
    else $error("reset entry state wrong");
  a_pin_const: assert property (!reset_pin_out) else $error("pin driven high");
  a_drive_len: assert property (
    $rose(reset_pin_oe_n_out) |-> lowcnt >= 16 && lowcnt <= OSC_DELAY_CYC + 17)
    else $error("drive phase length wrong");
  a_settle_nine: assert property ($rose(reset_pin_oe_n_out) |->
    (reset_pin_oe_n_out && cpu_reset_out)[*8] ##[1:2] (vector_valid_out && !cpu_reset_out))
    else $error("settle phase wrong");
  a_strap_hold: assert property (
    !cpu_reset_out && !$past(cpu_reset_out) |-> $stable(op_mode_out))
    else $error("mode changed after reset");
  a_pull_mode: assert property (
    mode_pulldown_out == cpu_reset_out && special_mode_pullup_out)
    else $error("strap pulls wrong");
  a_periph_in: assert property (
    !cpu_reset_out && op_mode_out == RSV_MODE_SPEC_PERIPH |-> bus_clock_oe_n_out)
    else $error("bus clock driven in peripheral mode");
  a_irq_defaults: assert property ($rose(resetn_in) |-> request_pin_enable_bit_out &&
    !request_edge_mode_out && request_mask_out && nonmaskable_mask_out && request_pullup_out)
    else $error("interrupt defaults wrong");
  c_clkmon: cover property ($rose(vector_valid_out) && vector_addr_out == RSV_VEC_CLKMON);
  c_wdog: cover property ($rose(vector_valid_out) && vector_addr_out == RSV_VEC_WATCHDOG);
  c_norm: cover property ($rose(vector_valid_out) && vector_addr_out == RSV_VEC_NORMAL);
endmodule
bind rsv_reset_sequencer rsv_sva #(.OSC_DELAY_CYC(OSC_DELAY_CYC)) sva_u (.*);

// File: testbench/rsv_ext_circuit.sv
// Reset pin circuit: pull-up, push button, optional slow rise
`timescale 1ns/1ps
module rsv_ext_circuit (
  input wire logic core_clk_in,
  input wire logic oe_n_in,
  input wire logic ext_low_in,
  input wire logic late_in,
  output logic pin_out
);
  logic [4:0] rise_cnt;
  // ======
  // Cycles since the device let go of the pin
  always_ff @(posedge core_clk_in) begin
    if (!oe_n_in) begin
      rise_cnt <= 5'h00;
    end else if (rise_cnt != 5'h1F) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end
  // Wired level; a slow rise misses the sample point
  assign pin_out = oe_n_in & ~ext_low_in & (~late_in | (rise_cnt > 5'h0F));
endmodule

// File: testbench/tb_top.sv
// Testbench for the reset sequencer
`timescale 1ns/1ps
module tb_top;
  import rsv_pkg::*;
  localparam int unsigned OSC = 8;
  logic core_clk_in, resetn_in = 1'h0, rd_in = 1'h0, wr_in = 1'h0, ext_low = 1'h0, late = 1'h0;
  logic watchdog_timer_timeout_in = 1'h0, watchdog_timer_enable_in = 1'h0;
  logic clock_monitor_fail_in = 1'h0, clock_monitor_enable_in = 1'h0;
  logic [2:0] strap = 3'h4;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  wire reset_pin_in, special_mode_pin_in, mode_select_pin_a_in, mode_select_pin_b_in;
  logic reset_pin_out, reset_pin_oe_n_out, cpu_reset_out, vector_valid_out, mode_pulldown_out;
  logic special_mode_pullup_out, queue_track_en_out, request_pin_enable_bit_out;
  logic request_edge_mode_out, request_mask_out, nonmaskable_mask_out, request_pullup_out;
  logic bus_clock_output_out, bus_clock_oe_n_out, rw_pullup_out, read_write_enable_bit_out;
  logic [15:0] vector_addr_out;
  logic [2:0] op_mode_out;
  logic [7:0] rdata_out;
  int err_count = 0;
  int compares = 0;
  // ======
  // Design, pin circuit and straps
  rsv_reset_sequencer #(.OSC_DELAY_CYC(OSC)) dut_u (.*);
  rsv_ext_circuit ext_u (.core_clk_in(core_clk_in), .oe_n_in(reset_pin_oe_n_out),
    .ext_low_in(ext_low), .late_in(late), .pin_out(reset_pin_in));
  assign {special_mode_pin_in, mode_select_pin_b_in, mode_select_pin_a_in} = strap;
  // Clock
  initial begin
    core_clk_in = 1'h0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic print_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge core_clk_in);
    wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge core_clk_in);
    rd_in <= 1'h0;
    @(negedge core_clk_in);
    d = rdata_out;
  endtask
  // Count drive cycles up to the vector, then check it
  task automatic seq(input logic [15:0] exp, input int lo);
    int n;
    int i;
    logic [7:0] d;
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge core_clk_in);
      if (reset_pin_oe_n_out === 1'h0) n++;
      if (n > 0 && vector_valid_out === 1'h1 && cpu_reset_out === 1'h0) break;
    end
    if (i == 300) begin
      check("timeout", 1'h1, 1'h0);
      print_verdict();
    end else begin
      if (lo > 0) check("drive", n >= lo && n <= lo + 1, 1'h1);
      check("vector", vector_addr_out, exp);
      rd(RSV_REG_VECTOR, d);
      check("vector reg", d, exp[7:0]);
    end
  endtask
  task automatic t_por(input logic [2:0] m);
    logic [7:0] d;
    @(posedge core_clk_in);
    strap <= m;
    resetn_in <= 1'h0;
    repeat (3) @(posedge core_clk_in);
    resetn_in <= 1'h1;
    seq(RSV_VEC_NORMAL, OSC + 16);
    check("mode", op_mode_out, m);
    rd(RSV_REG_INTERRUPT_CONTROL, d);
    check("intctl", d, RSV_IC_RESET);
    rd(RSV_REG_PULLUP_CONTROL, d);
    check("pullup", d, RSV_PU_RESET);
    rd(RSV_REG_PORT_E_ASSIGNMENT, d);
    if (m inside {RSV_MODE_USER_SINGLE, RSV_MODE_SPEC_SINGLE}) begin
      check("busclk on", d[RSV_PE_BUSCLK_BIT], m == RSV_MODE_SPEC_SINGLE);
    end
    check("busclk dir", bus_clock_oe_n_out, m == RSV_MODE_SPEC_PERIPH);
    check("rw pin", {rw_pullup_out, read_write_enable_bit_out}, 2'h2);
    rd(4'hF, d);
    check("unmapped", d, 8'h00);
    if (m[0]) begin
      wr(RSV_REG_PORT_E_ASSIGNMENT, 8'h04);
      @(negedge core_clk_in);
      check("queue", queue_track_en_out, 1'h1);
    end
  endtask
  task automatic t_cause(input logic [2:0] c, input logic en, input logic [15:0] exp,
    input int lo);
    @(posedge core_clk_in);
    watchdog_timer_enable_in <= en;
    clock_monitor_enable_in <= en;
    {ext_low, clock_monitor_fail_in, watchdog_timer_timeout_in} <= c;
    @(posedge core_clk_in);
    {ext_low, clock_monitor_fail_in, watchdog_timer_timeout_in} <= 3'h0;
    if (en) begin
      seq(exp, lo);
    end else begin
      repeat (40) @(posedge core_clk_in);
      check("gated", cpu_reset_out, 1'h0);
    end
  endtask
  task automatic t_regs();
    wr(RSV_REG_INTERRUPT_CONTROL, 8'h01);
    wr(RSV_REG_PULLUP_CONTROL, 8'h00);
    wr(RSV_REG_PORT_E_ASSIGNMENT, 8'h02);
    @(negedge core_clk_in);
    check("irq pins", {request_pin_enable_bit_out, request_edge_mode_out, request_mask_out,
      nonmaskable_mask_out, request_pullup_out}, 5'h08);
    check("rw enabled", {rw_pullup_out, read_write_enable_bit_out}, 2'h1);
  endtask
  // Main sequence
  initial begin
    t_por(RSV_MODE_USER_SINGLE);
    t_cause(3'h1, 1'h1, RSV_VEC_WATCHDOG, 16);
    t_cause(3'h3, 1'h1, RSV_VEC_CLKMON, OSC + 16);
    t_cause(3'h3, 1'h0, RSV_VEC_NORMAL, 0);
    t_cause(3'h4, 1'h1, RSV_VEC_NORMAL, 0);
    @(posedge core_clk_in) late <= 1'h1;
    t_cause(3'h1, 1'h1, RSV_VEC_NORMAL, 16);
    @(posedge core_clk_in) late <= 1'h0;
    t_por(RSV_MODE_SPEC_SINGLE);
    t_por(RSV_MODE_SPEC_PERIPH);
    t_por(3'h5);
    t_regs();
    print_verdict();
  end
endmodule
